// ---- stw_pkg.sv ----
// Constants and carriers for the start-up timing and input warning bank.
// Assumes a 10 MHz core clock; link-side transfers arrive as word commands.
package stw_pkg;
    // Command codes
    localparam logic [7:0] CMD_UV_WARN   = 8'h58;
    localparam logic [7:0] CMD_TURN_ON_DELAY_TIME = 8'h60;
    localparam logic [7:0] CMD_SOFT_START_RISE_TIME  = 8'h61;
    localparam logic [7:0] CMD_TON_MAX   = 8'h62;
    // Word layout and exponent reset values
    localparam int         EXP_MSB       = 15;
    localparam int         EXP_LSB       = 11;
    localparam int         MAN_MSB       = 10;
    localparam logic [4:0] UV_EXP_RST    = 5'h1e;
    localparam logic [4:0] DLY_EXP_RST   = 5'h1f;
    localparam logic [4:0] RISE_EXP_RST  = 5'h1e;
    localparam logic [4:0] MAX_EXP_RST   = 5'h1f;
    // Ranges: volts in 1/256 V, times in quarter milliseconds
    localparam int         UV_FRAC       = 8;
    localparam int         TIME_FRAC     = 2;
    localparam int         UV_MIN_Q8     = 640;
    localparam int         UV_MAX_Q8     = 3968;
    localparam int         DLY_MAX_Q2    = 510;
    localparam int         RISE_MAX_Q2   = 127;
    localparam int         RISE_MIN_Q2   = 2;
    localparam int         MAX_MAX_Q2    = 508;
    localparam int         PG_NUM        = 17;
    localparam int         PG_DEN        = 20;
    // Timing
    localparam int         CLK_PERIOD_NS = 100;
    localparam int         TICK_NS       = 250000;
    localparam int         TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int         INIT_NS       = 100000;
    localparam int         INIT_CYCLES   = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         TICKS_PER_MS  = 4;

    typedef struct packed {
        logic        write;
        logic [7:0]  code;
        logic [15:0] data;
    } stw_req_t;

    typedef struct packed {
        logic [15:0] uv_warn;
        logic [15:0] turn_on_delay_time;
        logic [15:0] soft_start_rise_time;
        logic [15:0] ton_max;
    } stw_nvm_t;

    typedef struct packed {
        logic none_above;
        logic input_bit;
        logic input_uv_warning_bit;
        logic cml_invalid_data;
        logic cml_invalid_cmd;
    } stw_status_t;

    // Signed linear word to fixed point with frac fractional bits
    function automatic logic signed [31:0] stw_lin_to_fix(input logic [15:0] w,
                                                        input int frac);
        logic signed [31:0] m;
        int                 sh;
        m  = 32'(signed'(w[MAN_MSB:0]));
        sh = int'(signed'(w[EXP_MSB:EXP_LSB])) + frac;
        if (sh >= 0)
            return m <<< sh;
        return m >>> (-sh);
    endfunction
endpackage

// ---- stw_link_port.sv ----
// Word command port: link-clock side capture and toggle handshake to the core.
// Assumes one transfer at a time; busy refuses new ones until the answer.
`timescale 1ns/100ps
`default_nettype none
module stw_link_port
    import stw_pkg::*;
(
    // Clocks and reset
    input  wire logic     ref_clk,
    input  wire logic     link_clk,
    input  wire logic     resetn,
    // Link side
    input  wire logic     link_wr,
    input  wire logic     link_rd,
    input  wire logic [7:0]  link_code,
    input  wire logic [15:0] link_wdata,
    output logic [15:0]   link_rdata,
    output logic          link_done,
    output logic          link_busy,
    // Core side
    output logic          req_valid,
    output stw_req_t      req,
    input  wire logic     rsp_valid,
    input  wire logic [15:0] rsp_data
);
    logic        req_tgl, next_req_tgl, ack_s1, ack_s2, ack_s3;
    logic        busy, next_busy, done, next_done;
    logic [15:0] rdata, next_rdata;
    stw_req_t    hold, next_hold;
    logic        req_s1, req_s2, req_s3, ack_tgl, next_ack_tgl;
    logic [15:0] ans, next_ans;

    // Link domain: the held request stays stable while the toggle crosses
    always_comb begin
        next_req_tgl = req_tgl;
        next_hold    = hold;
        next_busy    = busy;
        next_done    = 1'b0;
        next_rdata   = rdata;
        if (!busy && (link_wr || link_rd)) begin
            next_hold    = '{write: link_wr, code: link_code, data: link_wdata};
            next_req_tgl = ~req_tgl;
            next_busy    = 1'b1;
        end else if (busy && (ack_s3 != ack_s2)) begin
            next_rdata = ans;
            next_busy  = 1'b0;
            next_done  = 1'b1;
        end
    end

    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            req_tgl <= 1'b0;
            hold    <= '0;
            busy    <= 1'b0;
            done    <= 1'b0;
            rdata   <= 16'h0000;
            ack_s1  <= 1'b0;
            ack_s2  <= 1'b0;
            ack_s3  <= 1'b0;
        end else begin
            req_tgl <= next_req_tgl;
            hold    <= next_hold;
            busy    <= next_busy;
            done    <= next_done;
            rdata   <= next_rdata;
            ack_s1  <= ack_tgl;
            ack_s2  <= ack_s1;
            ack_s3  <= ack_s2;
        end
    end

    // Core domain: answer word is held until the next request
    always_comb begin
        next_ack_tgl = rsp_valid ? ~ack_tgl : ack_tgl;
        next_ans     = rsp_valid ? rsp_data : ans;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            req_s1  <= 1'b0;
            req_s2  <= 1'b0;
            req_s3  <= 1'b0;
            ack_tgl <= 1'b0;
            ans     <= 16'h0000;
        end else begin
            req_s1  <= req_tgl;
            req_s2  <= req_s1;
            req_s3  <= req_s2;
            ack_tgl <= next_ack_tgl;
            ans     <= next_ans;
        end
    end

    assign req_valid  = req_s2 != req_s3;
    assign req        = hold;
    assign link_rdata = rdata;
    assign link_done  = done;
    assign link_busy  = busy;
endmodule // stw_link_port
`default_nettype wire

// ---- stw_startup_regs.sv ----
// Start-up timing and input under-voltage warning command bank, one phase.
// Assumes word commands from the link port, telemetry on the core clock,
// and an open-drain alert pin resolved outside.
// Contract
// - Warn when input below threshold at 58h
// - Warning sets three status bits, alerts host
// - Each phase detects its own warning
// - Exponent 15:11, mantissa 10:0, exponent resets 11110b (delay and timeout exponents reset 11111b here)
// - Threshold accepted only 2.5V to 15.5V
// - Out-of-range write flags invalid data, alerts
// - Turn-on delay at 60h before rise
// - Delay 0 to 127.5ms, half-ms steps
// - Roughly 100us minimum delay after power-on
// - Reload rounds delay to nearest step
// - Rise time at 61h sets reference slew
// - Rise lasts programmed time, any setpoint
// - Rise 0 to 31.75ms, below 0.5ms applied 0.5ms
// - Rise default from memory or pin strap
// - Slew resolution limited, times may quantize
// - Timeout limit at 62h bounds power-up
// - Timeout from delay end to 85% setpoint
// - Under-voltage detection armed at rise end
// - Timeout 0 to 127ms, zero disables
// - Timeout response: ignore, delayed, immediate shutdown
`timescale 1ns/100ps
`default_nettype none
module stw_startup_regs
    import stw_pkg::*;
(
    // Clocks and reset
    input  wire logic        ref_clk,
    input  wire logic        link_clk,
    input  wire logic        resetn,
    // Command link
    input  wire logic        link_wr,
    input  wire logic        link_rd,
    input  wire logic [7:0]  link_code,
    input  wire logic [15:0] link_wdata,
    output logic [15:0]      link_rdata,
    output logic             link_done,
    output logic             link_busy,
    // Defaults and restore
    input  wire stw_nvm_t    nvm_defaults,
    input  wire logic        strap_rise_sel,
    input  wire logic [15:0] strap_rise,
    input  wire logic        restore_req,
    // Telemetry and control
    input  wire logic [15:0] power_stage_input,
    input  wire logic [15:0] vout_sense,
    input  wire logic [15:0] vout_setpoint,
    input  wire logic        start_pin,
    input  wire logic [7:0]  timeout_response,
    input  wire logic        clear_faults,
    // Status and alert
    output stw_status_t      status,
    output logic             alert_out,
    output logic             alert_oe_n,
    // Start-up sequence
    output logic [15:0]      ref_dac,
    output logic             ramp_active,
    output logic             uv_fault_armed,
    output logic             power_up_fault,
    output logic             shutdown
);
    typedef enum logic [2:0] {SQ_OFF, SQ_DELAY, SQ_RISE, SQ_ON, SQ_HOLD, SQ_STOP} stw_seq_t;

    logic        req_valid, rsp_valid, next_rsp_valid;
    stw_req_t    req;
    logic [15:0] rsp_data, next_rsp_data;
    logic [15:0] uv_lim, dly_lim, rise_lim, max_lim;
    logic [15:0] next_uv_lim, next_dly_lim, next_rise_lim, next_max_lim;
    logic        load_pend, next_load_pend;
    stw_status_t next_status;
    logic signed [31:0] wfix, uv_fix, dly_fix, rise_fix, max_fix, nvm_dly_fix;
    logic        wr_ok, uv_cond;
    logic [8:0]  dly_ticks;
    logic [6:0]  rise_ticks;
    logic [8:0]  max_ticks;
    logic        start_s1, start_s2;

    stw_link_port u_link (
        .ref_clk    (ref_clk),
        .link_clk   (link_clk),
        .resetn     (resetn),
        .link_wr    (link_wr),
        .link_rd    (link_rd),
        .link_code  (link_code),
        .link_wdata (link_wdata),
        .link_rdata (link_rdata),
        .link_done  (link_done),
        .link_busy  (link_busy),
        .req_valid  (req_valid),
        .req        (req),
        .rsp_valid  (rsp_valid),
        .rsp_data   (rsp_data)
    );

    // Applied values: times in quarter milliseconds, volts in 1/256 V
    always_comb begin
        uv_fix     = stw_lin_to_fix(uv_lim, UV_FRAC);
        dly_fix    = stw_lin_to_fix(dly_lim, TIME_FRAC);
        rise_fix   = stw_lin_to_fix(rise_lim, TIME_FRAC);
        max_fix    = stw_lin_to_fix(max_lim, TIME_FRAC);
        dly_ticks  = {dly_fix[8:1] + 8'(dly_fix[0]), 1'b0};
        // Short rise times would overshoot, so they are stretched
        rise_ticks = (rise_fix < RISE_MIN_Q2) ? 7'(RISE_MIN_Q2) : rise_fix[6:0];
        max_ticks  = {max_fix[8:1], 1'b0};
        uv_cond    = $signed({16'h0000, power_stage_input}) < uv_fix;
    end

    // Register writes, range checks and reload
    always_comb begin
        next_uv_lim    = uv_lim;
        next_dly_lim   = dly_lim;
        next_rise_lim  = rise_lim;
        next_max_lim   = max_lim;
        next_load_pend = load_pend | restore_req;
        next_status    = clear_faults ? '0 : status;
        next_rsp_valid = req_valid;
        next_rsp_data  = rsp_data;
        wfix           = stw_lin_to_fix(req.data, TIME_FRAC);
        nvm_dly_fix    = stw_lin_to_fix(nvm_defaults.turn_on_delay_time, TIME_FRAC);
        wr_ok          = 1'b0;
        if (load_pend) begin
            next_load_pend = 1'b0;
            next_uv_lim    = nvm_defaults.uv_warn;
            next_dly_lim   = {DLY_EXP_RST, 3'h0,
                              nvm_dly_fix[8:1] + 8'(nvm_dly_fix[0])};
            next_rise_lim  = strap_rise_sel ? strap_rise : nvm_defaults.soft_start_rise_time;
            next_max_lim   = nvm_defaults.ton_max;
        end else if (req_valid && req.write) begin
            unique case (req.code)
                CMD_UV_WARN: begin
                    wfix  = stw_lin_to_fix(req.data, UV_FRAC);
                    wr_ok = wfix >= UV_MIN_Q8 && wfix <= UV_MAX_Q8;
                    if (wr_ok)
                        next_uv_lim = req.data;
                end
                CMD_TURN_ON_DELAY_TIME: begin
                    wr_ok = wfix >= 0 && wfix <= DLY_MAX_Q2;
                    if (wr_ok)
                        next_dly_lim = req.data;
                end
                CMD_SOFT_START_RISE_TIME: begin
                    wr_ok = wfix >= 0 && wfix <= RISE_MAX_Q2;
                    if (wr_ok)
                        next_rise_lim = req.data;
                end
                CMD_TON_MAX: begin
                    wr_ok = wfix >= 0 && wfix <= MAX_MAX_Q2;
                    if (wr_ok)
                        next_max_lim = req.data;
                end
                default: next_status.cml_invalid_cmd = 1'b1;
            endcase
            if (!wr_ok && (req.code == CMD_UV_WARN || req.code == CMD_TURN_ON_DELAY_TIME ||
                           req.code == CMD_SOFT_START_RISE_TIME || req.code == CMD_TON_MAX)) begin
                next_status.cml_invalid_data = 1'b1;
                next_status.none_above       = 1'b1;
            end
        end else if (req_valid) begin
            unique case (req.code)
                CMD_UV_WARN:   next_rsp_data = uv_lim;
                CMD_TURN_ON_DELAY_TIME: next_rsp_data = dly_lim;
                CMD_SOFT_START_RISE_TIME:  next_rsp_data = rise_lim;
                CMD_TON_MAX:   next_rsp_data = max_lim;
                default: begin
                    next_rsp_data               = 16'h0000;
                    next_status.cml_invalid_cmd = 1'b1;
                end
            endcase
        end
        // Set wins over a clear in the same cycle
        if (uv_cond) begin
            next_status.none_above           = 1'b1;
            next_status.input_bit            = 1'b1;
            next_status.input_uv_warning_bit = 1'b1;
        end
        if (next_status.cml_invalid_cmd)
            next_status.none_above = 1'b1;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            uv_lim    <= {UV_EXP_RST, 11'h000};
            dly_lim   <= {DLY_EXP_RST, 11'h000};
            rise_lim  <= {RISE_EXP_RST, 11'h000};
            max_lim   <= {MAX_EXP_RST, 11'h000};
            load_pend <= 1'b1;
            status    <= '0;
            rsp_valid <= 1'b0;
            rsp_data  <= 16'h0000;
        end else begin
            uv_lim    <= next_uv_lim;
            dly_lim   <= next_dly_lim;
            rise_lim  <= next_rise_lim;
            max_lim   <= next_max_lim;
            load_pend <= next_load_pend;
            status    <= next_status;
            rsp_valid <= next_rsp_valid;
            rsp_data  <= next_rsp_data;
        end
    end

    // Alert pin pulls low while any status bit stands
    assign alert_out  = 1'b0;
    assign alert_oe_n = ~(|status);

    // Start-up sequencer
    stw_seq_t    seq, next_seq;
    logic [11:0] tick_cnt, next_tick_cnt;
    logic [9:0]  init_cnt, next_init_cnt;
    logic [9:0]  timer, next_timer, pu_timer, next_pu_timer;
    logic [15:0] slew, next_slew, next_ref_dac;
    logic        pu_done, next_pu_done, next_uv_armed, next_pu_fault;
    logic        tick, init_done, reached;

    always_comb begin
        tick      = tick_cnt == 12'(TICK_CYCLES - 1);
        init_done = init_cnt == 10'(INIT_CYCLES);
        reached   = 21'(vout_sense) * 21'(PG_DEN) >= 21'(vout_setpoint) * 21'(PG_NUM);
    end

    always_comb begin
        next_seq      = seq;
        next_tick_cnt = tick ? 12'h000 : tick_cnt + 12'h001;
        next_init_cnt = init_done ? init_cnt : init_cnt + 10'h001;
        next_timer    = timer;
        next_pu_timer = pu_timer;
        next_pu_done  = pu_done;
        next_slew     = slew;
        next_ref_dac  = ref_dac;
        next_uv_armed = uv_fault_armed;
        next_pu_fault = 1'b0;
        unique case (seq)
            SQ_OFF: begin
                next_ref_dac  = 16'h0000;
                next_uv_armed = 1'b0;
                if (start_s2) begin
                    next_seq   = SQ_DELAY;
                    next_timer = 10'h000;
                end
            end
            SQ_DELAY: begin
                if (tick)
                    next_timer = timer + 10'h001;
                if (timer >= 10'(dly_ticks) && init_done) begin
                    next_seq      = SQ_RISE;
                    next_timer    = 10'h000;
                    next_pu_timer = 10'h000;
                    next_pu_done  = 1'b0;
                    // Truncated step: long rises at low setpoints quantize
                    next_slew     = vout_setpoint / 16'(rise_ticks);
                end
            end
            SQ_RISE: begin
                if (tick) begin
                    next_timer   = timer + 10'h001;
                    next_ref_dac = ref_dac + slew;
                    if (timer + 10'h001 >= 10'(rise_ticks)) begin
                        next_ref_dac  = vout_setpoint;
                        next_seq      = SQ_ON;
                        next_uv_armed = 1'b1;
                    end
                end
            end
            SQ_ON:   next_ref_dac = vout_setpoint;
            SQ_HOLD: begin
                if (tick)
                    next_timer = timer + 10'h001;
                if (reached)
                    next_seq = SQ_ON;
                else if (timer >= 10'({timeout_response[2:0], 2'b00} + 5'h04))
                    next_seq = SQ_STOP;
            end
            SQ_STOP: begin
                next_ref_dac  = 16'h0000;
                next_uv_armed = 1'b0;
            end
        endcase
        // Power-up timeout runs from the end of the delay
        if ((seq == SQ_RISE || seq == SQ_ON) && !pu_done) begin
            if (reached)
                next_pu_done = 1'b1;
            else if (tick)
                next_pu_timer = pu_timer + 10'h001;
            if (!reached && max_ticks != 9'h000 && pu_timer >= 10'(max_ticks)) begin
                next_pu_fault = 1'b1;
                next_pu_done  = 1'b1;
                unique case (timeout_response[7:6])
                    2'b01: begin
                        next_seq   = SQ_HOLD;
                        next_timer = 10'h000;
                    end
                    2'b10:   next_seq = SQ_STOP;
                    default: next_seq = next_seq;
                endcase
            end
        end
        if (!start_s2)
            next_seq = SQ_OFF;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            start_s1       <= 1'b0;
            start_s2       <= 1'b0;
            seq            <= SQ_OFF;
            tick_cnt       <= 12'h000;
            init_cnt       <= 10'h000;
            timer          <= 10'h000;
            pu_timer       <= 10'h000;
            pu_done        <= 1'b0;
            slew           <= 16'h0000;
            ref_dac        <= 16'h0000;
            uv_fault_armed <= 1'b0;
            power_up_fault <= 1'b0;
        end else begin
            start_s1       <= start_pin;
            start_s2       <= start_s1;
            seq            <= next_seq;
            tick_cnt       <= next_tick_cnt;
            init_cnt       <= next_init_cnt;
            timer          <= next_timer;
            pu_timer       <= next_pu_timer;
            pu_done        <= next_pu_done;
            slew           <= next_slew;
            ref_dac        <= next_ref_dac;
            uv_fault_armed <= next_uv_armed;
            power_up_fault <= next_pu_fault;
        end
    end

    assign ramp_active = seq == SQ_RISE;
    assign shutdown    = seq == SQ_STOP;
endmodule // stw_startup_regs
`default_nettype wire

// ---- stw_startup_regs_properties.sv ----
// Port checks for the start-up timing bank.
// Assumes a bind onto stw_startup_regs from the bench.
`timescale 1ns/100ps
`default_nettype none
module stw_startup_regs_properties
    import stw_pkg::*;
(
    // Clocks and reset
    input wire logic        ref_clk,
    input wire logic        link_clk,
    input wire logic        resetn,
    // Watched
    input wire logic        link_busy,
    input wire logic        link_done,
    input wire logic        clear_faults,
    input wire stw_status_t status,
    input wire logic        alert_out,
    input wire logic        alert_oe_n,
    input wire logic        ramp_active,
    input wire logic        uv_fault_armed,
    input wire logic        power_up_fault
);
    sequence s_answer;
        link_busy [*4] ##[1:400] link_done;
    endsequence
    property p_answer;
        @(posedge link_clk) disable iff (!resetn) $rose(link_busy) |-> s_answer;
    endproperty
    property p_done;
        @(posedge link_clk) disable iff (!resetn) link_done |-> !link_busy ##1 !link_done;
    endproperty
    property p_alert;
        @(posedge ref_clk) disable iff (!resetn) alert_oe_n == !(|status) && !alert_out;
    endproperty
    property p_uvw;
        @(posedge ref_clk) disable iff (!resetn)
            status.input_uv_warning_bit |-> status.none_above && status.input_bit;
    endproperty
    property p_inv;
        @(posedge ref_clk) disable iff (!resetn)
            (status.cml_invalid_data || status.cml_invalid_cmd) |-> status.none_above;
    endproperty
    // Summary flag is sticky: only a clear may drop it
    property p_sticky;
        @(posedge ref_clk) disable iff (!resetn) $fell(status.none_above) |-> $past(clear_faults);
    endproperty
    property p_fault;
        @(posedge ref_clk) disable iff (!resetn) power_up_fault |=> !power_up_fault;
    endproperty
    property p_arm;
        @(posedge ref_clk) disable iff (!resetn) $rose(uv_fault_armed) |-> !ramp_active;
    endproperty
    property p_ramp;
        @(posedge ref_clk) disable iff (!resetn) $rose(ramp_active) |-> !uv_fault_armed;
    endproperty
    a_answer: assert property (p_answer) else $error("link answer late");
    a_done: assert property (p_done) else $error("done not a pulse");
    a_alert: assert property (p_alert) else $error("alert wrong");
    a_uvw: assert property (p_uvw) else $error("warning bits apart");
    a_inv: assert property (p_inv) else $error("invalid without summary");
    a_sticky: assert property (p_sticky) else $error("flag lost");
    a_fault: assert property (p_fault) else $error("fault not a pulse");
    a_arm: assert property (p_arm) else $error("armed in rise");
    a_ramp: assert property (p_ramp) else $error("rise while armed");
endmodule // stw_startup_regs_properties
`default_nettype wire

// ---- stw_host_model.sv ----
// Host model: word transfers on the command link.
// Assumes the bench calls xfer; the link clock runs only in reset and frames.
`timescale 1ns/100ps
`default_nettype none
module stw_host_model (
    // Control
    input  wire logic  resetn,
    input  wire logic  link_done,
    // Link
    output logic       link_clk,
    output logic       link_wr,
    output logic       link_rd,
    output logic [7:0] link_code,
    output logic [15:0] link_wdata
);
    logic run = 1'b0;
    initial {link_clk, link_wr, link_rd, link_code, link_wdata} = '0;
    always #3 if (run || !resetn) link_clk = ~link_clk;
    // One word each way, next only after the answer
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
        run = 1'b1;
        @(negedge link_clk);
        {link_wr, link_rd} = {w, !w};
        link_code  = c;
        link_wdata = d;
        @(negedge link_clk);
        {link_wr, link_rd} = 2'b00;
        // Released lines show the inverse, never a stale copy
        link_code  = ~c;
        link_wdata = ~d;
        for (int n = 0; n < 500 && link_done !== 1'b1; n++)
            @(negedge link_clk);
        @(negedge link_clk);
        run = 1'b0;
    endtask
endmodule // stw_host_model
`default_nettype wire

// ---- test_stw_startup_regs.sv ----
// Bench for the start-up timing and input warning bank.
// Assumes the host model drives the link; all else is driven here.
`timescale 1ns/100ps
`default_nettype none
module test_stw_startup_regs
    import stw_pkg::*;
;
    logic        ref_clk, resetn, strap_rise_sel, restore_req, start_pin, clear_faults, a;
    logic        link_clk, link_wr, link_rd, link_done, link_busy, alert_out, alert_oe_n;
    logic        ramp_active, uv_fault_armed, power_up_fault, shutdown;
    logic        seen_fault = 1'b0;
    logic [7:0]  link_code, timeout_response, c;
    logic [15:0] link_wdata, link_rdata, strap_rise, power_stage_input, d;
    logic [15:0] vout_sense, vout_setpoint, ref_dac;
    logic [15:0] shadow[4];
    logic [16:0] e;
    logic [16:0] exp_q[$];
    logic [7:0]  codes[4] = '{CMD_UV_WARN, CMD_TURN_ON_DELAY_TIME, CMD_SOFT_START_RISE_TIME, CMD_TON_MAX};
    logic [24:0] tbl[10] = '{25'h058f009, 25'h158f00a, 25'h158f03e, 25'h058f03f, 25'h060f900,
                             25'h160f8ff, 25'h061f080, 25'h161f07f, 25'h062f8ff, 25'h162f8fe};
    stw_nvm_t    nvm_defaults;
    stw_status_t status;
    int          failures = 0, comparisons = 0, n, t0, k;
    stw_startup_regs stw_startup_regs_inst (.*);
    stw_host_model stw_host_model_inst (.*);
    task automatic check(input logic [15:0] got, input logic [15:0] want);
        comparisons++;
        if (got !== want) begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic final_report();
        if (failures == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cyc(input int m);
        repeat (m) @(negedge ref_clk);
    endtask
    // Reads carry the expected word as data; the port ignores it
    task automatic xf(input logic w, input logic [7:0] cc, input logic [15:0] dd);
        exp_q.push_back({!w, dd});
        stw_host_model_inst.xfer(w, cc, dd);
    endtask
    task automatic clr();
        cyc(1);
        clear_faults = 1'b1;
        cyc(1);
        clear_faults = 1'b0;
        cyc(2);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(negedge link_clk) begin
        if (link_done === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e[16]) check(link_rdata, e[15:0]);
        end
    end
    always @(posedge ref_clk) if (power_up_fault === 1'b1) seen_fault <= 1'b1;
    initial begin
        #6000000;
        failures++;
        final_report();
    end
    initial begin
        void'($urandom(59));
        {resetn, strap_rise_sel, restore_req, start_pin, clear_faults} = '0;
        nvm_defaults = {16'hf000 | 16'(10 + $urandom % 53), 16'hf808, 16'hf00a, 16'hf8fe};
        strap_rise = 16'hf000 | 16'($urandom % 128);
        power_stage_input = 16'h1000;
        vout_sense = 16'h0000;
        vout_setpoint = 16'h0100;
        timeout_response = 8'h80;
        repeat (8) @(negedge ref_clk);
        resetn = 1'b1;
        cyc(3);
        for (int i = 0; i < 4; i++) begin
            shadow[i] = nvm_defaults[63 - 16 * i -: 16];
            xf(1'b0, codes[i], shadow[i]);
        end
        cyc(1);
        strap_rise_sel = 1'b1;
        nvm_defaults.turn_on_delay_time = 16'he805;
        restore_req = 1'b1;
        cyc(1);
        restore_req = 1'b0;
        cyc(3);
        shadow[1] = 16'hf801;
        shadow[2] = strap_rise;
        xf(1'b0, CMD_SOFT_START_RISE_TIME, shadow[2]);
        xf(1'b0, CMD_TURN_ON_DELAY_TIME, shadow[1]);
        // Range edges, the edge value itself and one step outside
        for (int i = 0; i < 10; i++) begin
            {a, c, d} = tbl[i];
            k = (c == CMD_UV_WARN) ? 0 : int'(c) - 'h5f;
            clr();
            xf(1'b1, c, d);
            if (a) shadow[k] = d;
            xf(1'b0, c, shadow[k]);
            cyc(2);
            check(16'(status.cml_invalid_data), 16'(!a));
            check(16'(alert_oe_n), 16'(a));
        end
        clr();
        xf(1'b0, 8'h59, 16'h0000);
        cyc(2);
        check(16'(status.cml_invalid_cmd), 16'h0001);
        power_stage_input = 16'd3967;
        cyc(3);
        check(16'(status[4:2]), 16'h0007);
        power_stage_input = 16'd3968;
        clr();
        check(16'(status[4:2]), 16'h0000);
        xf(1'b1, CMD_TURN_ON_DELAY_TIME, 16'hf802);
        xf(1'b1, CMD_SOFT_START_RISE_TIME, 16'hf000);
        xf(1'b1, CMD_TON_MAX, 16'hf802);
        cyc(1);
        start_pin = 1'b1;
        for (n = 0; ramp_active !== 1'b1 && n < 12000; n++)
            cyc(1);
        check(16'(n > 7400 && n < 10100), 16'h0001);
        for (t0 = 0; ramp_active === 1'b1 && t0 < 12000; t0++)
            cyc(1);
        check(16'(t0 > 4900 && t0 < 5100), 16'h0001);
        cyc(1);
        check(ref_dac, vout_setpoint);
        check(16'(uv_fault_armed), 16'h0001);
        while (seen_fault !== 1'b1 && t0 < 12000) begin
            cyc(1);
            t0++;
        end
        check(16'(t0 > 9800 && t0 < 10200), 16'h0001);
        cyc(2);
        check(16'(shutdown), 16'h0001);
        start_pin = 1'b0;
        xf(1'b1, CMD_TON_MAX, 16'hf800);
        cyc(1);
        vout_setpoint = 16'h0380;
        seen_fault = 1'b0;
        start_pin = 1'b1;
        cyc(20000);
        check(16'(seen_fault), 16'h0000);
        check(ref_dac, vout_setpoint);
        start_pin = 1'b0;
        cyc(5);
        final_report();
    end
endmodule // test_stw_startup_regs
bind stw_startup_regs stw_startup_regs_properties chk (.*);
`default_nettype wire
